/* File: hdl/seew_slave.sv */
// I2C write slave front end of a 64-Kb serial EEPROM
`timescale 1ns/1ns
`default_nettype none
`include "seew_defines.svh"
// Overview of operation
// - Power-on reset puts device in standby
// - Sample SDA on SCL rise, drive after fall
// - Address select bits must match strap pins
// - Write protect high at the first data byte refuses all writes of that frame
// - SDA held steady while SCL high
// - Falling SDA with SCL high is START
// - Rising SDA with SCL high is STOP
// - Address byte: type code, straps, direction
// - Receiver acknowledges on ninth clock
// - Byte write: address, two pointers, data, STOP
// - STOP starts write cycle, no acknowledge
// - Page buffer takes up to 32 bytes
// - In-page address wraps, page fixed
// - Whole page committed in one cycle
// - Filter short pulses on SCL and SDA
// - Write protect sampled before first data byte
module seew_slave #(
	parameter int WR_CYCLES = `SEEW_WR_CYCLES,
	parameter logic [3:0] TYPE_CODE = `SEEW_TYPE_CODE_DEFAULT // Arbitrary value
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic strap_select_bit0,
	input wire logic strap_select_bit1,
	input wire logic strap_select_bit2,
	input wire logic write_protect,
	output logic write_busy,
	output logic commit_pulse,
	output logic [7:0] commit_page,
	output logic [31:0] commit_mask,
	output logic [255:0] commit_data
);
	import seew_pkg::*;

	logic scl_f;
	logic sda_f;
	logic scl_d_ff;
	logic sda_d_ff;
	logic [2:0] strap_m_ff;
	logic [2:0] strap_ff;
	logic wp_m_ff;
	logic wp_ff;
	seew_state_t state_ff;
	seew_state_t nxt_state;
	logic [3:0] bit_ff;
	logic [3:0] nxt_bit;
	logic [7:0] shift_ff;
	logic [7:0] nxt_shift;
	logic ack_ff;
	logic nxt_ack;
	logic drive_ff;
	logic nxt_drive;
	logic [12:0] ptr_ff;
	logic [12:0] nxt_ptr;
	logic [7:0] mem_ff [`SEEW_PAGE_BYTES];
	logic [31:0] mask_ff;
	logic [31:0] nxt_mask;
	logic wp_lat_ff;
	logic nxt_wp_lat;
	logic [23:0] wr_cnt_ff;
	logic [23:0] nxt_wr_cnt;
	logic busy_ff;
	logic nxt_busy;
	logic commit_ff;
	logic nxt_commit;
	logic [7:0] cpage_ff;
	logic [7:0] nxt_cpage;
	logic wr_en;
	logic [4:0] wr_idx;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic byte_done;

	seew_glitch_filter u_scl_filt (.clk(clk), .rstn(rstn), .pin_in(scl_in), .level_out(scl_f));
	seew_glitch_filter u_sda_filt (.clk(clk), .rstn(rstn), .pin_in(sda_in), .level_out(sda_f));

	assign scl_rise = scl_f && !scl_d_ff;
	assign scl_fall = !scl_f && scl_d_ff;
	assign start_c = scl_f && scl_d_ff && sda_d_ff && !sda_f;
	assign stop_c = scl_f && scl_d_ff && !sda_d_ff && sda_f;
	assign byte_done = scl_fall && (bit_ff == 4'h8);

	always_comb begin
		nxt_state = state_ff;
		nxt_bit = bit_ff;
		nxt_shift = shift_ff;
		nxt_ack = ack_ff;
		nxt_drive = drive_ff;
		nxt_ptr = ptr_ff;
		nxt_mask = mask_ff;
		nxt_wp_lat = wp_lat_ff;
		nxt_wr_cnt = wr_cnt_ff;
		nxt_busy = busy_ff;
		nxt_commit = 1'b0;
		nxt_cpage = cpage_ff;
		wr_en = 1'b0;
		wr_idx = ptr_ff[4:0];
		if (busy_ff) begin
			nxt_wr_cnt = wr_cnt_ff - 24'h1;
			if (wr_cnt_ff == 24'h1) begin
				nxt_busy = 1'b0;
				nxt_commit = 1'b1;
			end
		end
		if (start_c) begin
			nxt_state = ST_DEVADDR;
			nxt_bit = `SEEW_BIT_CNT_RST;
			nxt_drive = 1'b0;
		end else if (stop_c) begin
			nxt_state = ST_IDLE;
			nxt_drive = 1'b0;
			if (state_ff == ST_DATA && mask_ff != 32'h0 && !busy_ff) begin
				nxt_busy = 1'b1;
				nxt_wr_cnt = 24'(WR_CYCLES);
				nxt_cpage = ptr_ff[12:5];
			end
		end else if (state_ff != ST_IDLE && state_ff != ST_IGNORE) begin
			if (scl_rise && bit_ff < 4'h8) begin
				nxt_shift = {shift_ff[6:0], sda_f};
				nxt_bit = bit_ff + 4'h1;
			end else if (scl_rise && bit_ff == 4'h8) begin
				nxt_bit = 4'h9;
			end
			if (byte_done) begin
				nxt_ack = 1'b0;
				unique case (state_ff)
					ST_DEVADDR: begin
						if (shift_ff[7:4] == TYPE_CODE && shift_ff[3:1] == strap_ff
							&& !shift_ff[0] && !busy_ff) begin
							nxt_ack = 1'b1;
							nxt_state = ST_ADDR_HI;
						end else begin
							nxt_state = ST_IGNORE;
						end
					end
					ST_ADDR_HI: begin
						nxt_ack = 1'b1;
						nxt_ptr = {shift_ff[4:0], ptr_ff[7:0]};
						nxt_state = ST_ADDR_LO;
					end
					ST_ADDR_LO: begin
						nxt_ack = 1'b1;
						nxt_ptr = {ptr_ff[12:8], shift_ff};
						nxt_mask = 32'h0;
						nxt_state = ST_DATA;
					end
					ST_DATA: begin
						if (wp_lat_ff) begin
							nxt_state = ST_IGNORE;
							nxt_mask = 32'h0;
						end else begin
							nxt_ack = 1'b1;
							wr_en = 1'b1;
							nxt_mask = mask_ff | (32'h1 << ptr_ff[4:0]);
							nxt_ptr = {ptr_ff[12:5], ptr_ff[4:0] + 5'h1};
						end
					end
					default: nxt_state = ST_IGNORE;
				endcase
				nxt_drive = nxt_ack;
			end else if (scl_fall && bit_ff == 4'h9) begin
				nxt_drive = 1'b0;
				nxt_bit = `SEEW_BIT_CNT_RST;
				// Strobed once, at the fall just ahead of the first data byte
				if (state_ff == ST_DATA && mask_ff == 32'h0) begin
					nxt_wp_lat = wp_ff;
				end
				if (!ack_ff) begin
					nxt_state = ST_IGNORE;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
			strap_m_ff <= 3'h0;
			strap_ff <= 3'h0;
			wp_m_ff <= 1'b0;
			wp_ff <= 1'b0;
			state_ff <= ST_IDLE;
			bit_ff <= `SEEW_BIT_CNT_RST;
			shift_ff <= 8'h00;
			ack_ff <= 1'b0;
			drive_ff <= 1'b0;
			ptr_ff <= 13'h0000;
			mask_ff <= 32'h0;
			wp_lat_ff <= 1'b0;
			wr_cnt_ff <= 24'h0;
			busy_ff <= 1'b0;
			commit_ff <= 1'b0;
			cpage_ff <= 8'h00;
		end else begin
			scl_d_ff <= scl_f;
			sda_d_ff <= sda_f;
			strap_m_ff <= {strap_select_bit2, strap_select_bit1, strap_select_bit0};
			strap_ff <= strap_m_ff;
			wp_m_ff <= write_protect;
			wp_ff <= wp_m_ff;
			state_ff <= nxt_state;
			bit_ff <= nxt_bit;
			shift_ff <= nxt_shift;
			ack_ff <= nxt_ack;
			drive_ff <= nxt_drive;
			ptr_ff <= nxt_ptr;
			mask_ff <= nxt_mask;
			wp_lat_ff <= nxt_wp_lat;
			wr_cnt_ff <= nxt_wr_cnt;
			busy_ff <= nxt_busy;
			commit_ff <= nxt_commit;
			cpage_ff <= nxt_cpage;
		end
	end

	// Page buffer, no reset needed on data
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_ff[wr_idx] <= shift_ff;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `SEEW_PAGE_BYTES; gi++) begin : g_out
			assign commit_data[gi*8 +: 8] = mem_ff[gi];
		end
	endgenerate

	assign sda_out = 1'b0;
	assign sda_oe = drive_ff;
	assign write_busy = busy_ff;
	assign commit_pulse = commit_ff;
	assign commit_page = cpage_ff;
	assign commit_mask = mask_ff;

	wr_busy_ack_a: assert property (@(posedge clk) disable iff (!rstn)
		busy_ff && state_ff == ST_DEVADDR && byte_done |=> !drive_ff)
		else $error("ack given during write cycle");
	stop_launch_a: assert property (@(posedge clk) disable iff (!rstn)
		stop_c && state_ff == ST_DATA && mask_ff != 32'h0 && !busy_ff |=> busy_ff)
		else $error("stop did not start write");
	wp_refuse_a: assert property (@(posedge clk) disable iff (!rstn)
		byte_done && state_ff == ST_DATA && wp_lat_ff |=> !drive_ff && state_ff == ST_IGNORE)
		else $error("protected byte acknowledged");
	mismatch_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == ST_IGNORE |-> !drive_ff)
		else $error("sda driven while ignoring");
	start_detect_a: assert property (@(posedge clk) disable iff (!rstn)
		start_c |=> state_ff == ST_DEVADDR && bit_ff == 4'h0)
		else $error("start not detected");
	stop_idle_a: assert property (@(posedge clk) disable iff (!rstn)
		stop_c |=> state_ff == ST_IDLE && !drive_ff)
		else $error("stop not honoured");
	page_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
		wr_en |=> ptr_ff[12:5] == $past(ptr_ff[12:5]))
		else $error("page address moved");
	ack_release_a: assert property (@(posedge clk) disable iff (!rstn)
		scl_fall && bit_ff == 4'h9 |=> !drive_ff)
		else $error("ack not released");
	commit_end_a: assert property (@(posedge clk) disable iff (!rstn)
		busy_ff && wr_cnt_ff == 24'h1 |=> commit_ff && !busy_ff)
		else $error("commit missing");
	idle_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
		state_ff == ST_IDLE |-> !drive_ff)
		else $error("sda driven when idle");

	cov_page_c: cover property (@(posedge clk) disable iff (!rstn) wr_en && ptr_ff[4:0] == 5'h1F);
	cov_commit_c: cover property (@(posedge clk) disable iff (!rstn) commit_ff);
	cov_wp_c: cover property (@(posedge clk) disable iff (!rstn) wp_lat_ff && byte_done);
endmodule
`default_nettype wire

/* File: hdl/seew_defines.svh */
// Timing and protocol constants for the serial EEPROM write slave
`ifndef SEEW_DEFINES_SVH
`define SEEW_DEFINES_SVH

`define SEEW_CLK_MHZ 25
`define SEEW_WR_TIME_MS 4
`define SEEW_WR_CYCLES (`SEEW_WR_TIME_MS * 1000 * `SEEW_CLK_MHZ)
`define SEEW_FILT_NS 50
`define SEEW_CLK_NS 40
`define SEEW_FILT_CYCLES ((`SEEW_FILT_NS + `SEEW_CLK_NS - 1) / `SEEW_CLK_NS)
`define SEEW_TYPE_CODE_DEFAULT 4'h5
`define SEEW_ADDR_W 13
`define SEEW_PAGE_BYTES 32
`define SEEW_BIT_CNT_RST 4'h0

`endif

/* File: hdl/seew_pkg.sv */
// Types for the serial EEPROM write slave
package seew_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEVADDR,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_DATA,
		ST_IGNORE
	} seew_state_t;
endpackage

/* File: hdl/seew_glitch_filter.sv */
// Two-flop synchroniser and pulse filter for one bus input
`timescale 1ns/1ns
`default_nettype none
`include "seew_defines.svh"
module seew_glitch_filter (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin_in,
	output logic level_out
);
	logic meta_ff;
	logic sync_ff;
	logic [1:0] cnt_ff;
	logic lvl_ff;
	logic [1:0] nxt_cnt;
	logic nxt_lvl;

	// Level only follows after it holds longer than the filter limit
	always_comb begin
		nxt_cnt = 2'h0;
		nxt_lvl = lvl_ff;
		if (sync_ff != lvl_ff) begin
			nxt_cnt = cnt_ff + 2'h1;
			if (cnt_ff >= 2'(`SEEW_FILT_CYCLES)) begin
				nxt_lvl = sync_ff;
				nxt_cnt = 2'h0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			cnt_ff <= 2'h0;
			lvl_ff <= 1'b1;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			cnt_ff <= nxt_cnt;
			lvl_ff <= nxt_lvl;
		end
	end

	assign level_out = lvl_ff;
endmodule
`default_nettype wire

/* File: tb/seew_master_model.sv */
// Behavioural bus master that drives SCL and SDA towards the slave
`timescale 1ns/1ns
`default_nettype none
module seew_master_model (
	input wire logic clk,
	input wire logic sda_line,
	output var logic scl,
	output var logic sda_rel
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start();
		sda_rel <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_rel <= 1'b0;
		tick(4);
		scl <= 1'b0;
		tick(2);
	endtask
	task automatic put_bit(input logic b, output logic seen);
		sda_rel <= b;
		tick(2);
		scl <= 1'b1;
		tick(4);
		seen = sda_line;
		scl <= 1'b0;
		tick(2);
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], s);
		end
		// Stretched low phases leave room for the slave's input latency
		tick(4);
		put_bit(1'b1, s);
		ack = ~s;
		tick(6);
	endtask
	task automatic stop();
		sda_rel <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_rel <= 1'b1;
		tick(8);
	endtask
endmodule
`default_nettype wire

/* File: tb/serial_eeprom_i2c_write_slave_bench.sv */
// Self-checking bench for the serial EEPROM write slave
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_i2c_write_slave_bench;
	localparam logic [3:0] TYPE_CODE = 4'h9; // Arbitrary value
	logic clk;
	logic rstn;
	logic scl;
	logic sda_rel;
	logic sda_line;
	logic sda_out;
	logic sda_oe;
	logic [2:0] strap;
	logic write_protect;
	logic write_busy;
	logic commit_pulse;
	logic [7:0] commit_page;
	logic [31:0] commit_mask;
	logic [255:0] commit_data;
	logic [255:0] exp;
	logic [63:0] acks;
	int err_total;
	int tests_run;
	// Pulled-up open-drain wire
	assign sda_line = sda_rel & (sda_oe ? sda_out : 1'b1);
	seew_slave #(.WR_CYCLES(400), .TYPE_CODE(TYPE_CODE)) seew_slave_inst (
		.clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .strap_select_bit0(strap[0]), .strap_select_bit1(strap[1]),
		.strap_select_bit2(strap[2]), .write_protect(write_protect),
		.write_busy(write_busy), .commit_pulse(commit_pulse), .commit_page(commit_page),
		.commit_mask(commit_mask), .commit_data(commit_data)
	);
	seew_master_model seew_master_model_inst (
		.clk(clk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel)
	);
	task automatic check(input logic [255:0] got, input logic [255:0] want);
		tests_run++;
		if (got !== want) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic frame(input logic [7:0] dev, input logic [15:0] ptr, input int n);
		logic a;
		logic [7:0] b;
		acks = '0;
		seew_master_model_inst.start();
		for (int k = 0; k < n + 3; k++) begin
			b = (k == 0) ? dev : (k == 1) ? ptr[15:8] : (k == 2) ? ptr[7:0] : 8'(8'h10 + k);
			seew_master_model_inst.send_byte(b, a);
			acks[k] = a;
		end
		seew_master_model_inst.stop();
	endtask
	task automatic wait_commit();
		int c;
		c = 0;
		while (commit_pulse !== 1'b1 && c < 600) begin
			@(posedge clk);
			c++;
		end
		check(commit_pulse, 1'b1);
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		complete_run();
	end
	initial begin
		rstn = 1'b0;
		strap = 3'b101;
		write_protect = 1'b0;
		err_total = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (20) @(posedge clk);
		frame({TYPE_CODE, 3'b101, 1'b0}, 16'hE345, 1);
		check(acks, 64'hF);
		check(write_busy, 1'b1);
		frame({TYPE_CODE, 3'b101, 1'b0}, 16'h0000, 0);
		check(acks, 64'h0);
		wait_commit();
		check(commit_page, 8'h1A);
		check(commit_mask, 32'h20);
		check(commit_data[47:40], 8'h13);
		$display("Test byte write done");
		frame({TYPE_CODE, 3'b101, 1'b0}, 16'h003E, 34);
		check(acks, 64'h1F_FFFF_FFFF);
		exp = '0;
		for (int i = 0; i < 34; i++) begin
			exp[8 * ((30 + i) % 32) +: 8] = 8'(8'h13 + i);
		end
		wait_commit();
		check(commit_page, 8'h01);
		check(commit_mask, 32'hFFFF_FFFF);
		check(commit_data, exp);
		$display("Test page write done");
		frame({TYPE_CODE, 3'b100, 1'b0}, 16'h0010, 1);
		check(acks, 64'h0);
		frame({TYPE_CODE, 3'b101, 1'b1}, 16'h0010, 1);
		check(acks, 64'h0);
		frame({~TYPE_CODE, 3'b101, 1'b0}, 16'h0010, 1);
		check(acks, 64'h0);
		check(write_busy, 1'b0);
		@(posedge clk);
		strap <= 3'b010;
		write_protect <= 1'b1;
		frame({TYPE_CODE, 3'b010, 1'b0}, 16'h0010, 1);
		check(acks, 64'h7);
		check(write_busy, 1'b0);
		$display("Test refusals done");
		@(posedge clk);
		write_protect <= 1'b0;
		frame({TYPE_CODE, 3'b010, 1'b0}, 16'h1FFF, 1);
		check(acks, 64'hF);
		wait_commit();
		check(commit_page, 8'hFF);
		check(commit_mask, 32'h8000_0000);
		$display("Test strap change done");
		frame({TYPE_CODE, 3'b010, 1'b0}, 16'h0040, 1);
		check(write_busy, 1'b1);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		check(write_busy, 1'b0);
		check(commit_mask, 32'h0);
		check(sda_oe, 1'b0);
		rstn <= 1'b1;
		repeat (20) @(posedge clk);
		frame({TYPE_CODE, 3'b010, 1'b0}, 16'h0041, 1);
		check(acks, 64'hF);
		wait_commit();
		check(commit_page, 8'h02);
		check(commit_mask, 32'h2);
		$display("Test brown-out done");
		complete_run();
	end
endmodule
`default_nettype wire
